// ==== design/seg_desc_pkg.sv ====
package seg_desc_pkg;

  // ----------------------------------------------------------------
  // Access byte fields
  // ----------------------------------------------------------------
  localparam int PRESENT_BIT = 7;
  localparam int LEVEL_HI = 6;
  localparam int LEVEL_LO = 5;
  localparam int CLASS_BIT = 4;
  localparam int EXEC_BIT = 3;
  localparam int CONF_BIT = 2;
  localparam int RW_BIT = 1;
  localparam int ACCESSED_BIT = 0;
  // Flag nibble bits (descriptor bits 55..52)
  localparam int GRAN_BIT = 55;
  localparam int SIZE_BIT = 54;

  // ----------------------------------------------------------------
  // Exceptions and system types
  // ----------------------------------------------------------------
  localparam logic [7:0] VEC_NOT_PRESENT = 8'h0B;
  localparam logic [7:0] VEC_PROTECTION = 8'h0D;
  localparam logic [3:0] TYPE_LOCAL_TABLE = 4'h2;
  localparam logic [3:0] TYPE_TASK_NARROW_FREE = 4'h1;
  localparam logic [3:0] TYPE_TASK_NARROW_BUSY = 4'h3;
  localparam logic [3:0] TYPE_TASK_WIDE_FREE = 4'h9;
  localparam logic [3:0] TYPE_TASK_WIDE_BUSY = 4'hB;
  localparam logic [11:0] PAGE_FILL = 12'hFFF;
  localparam logic [31:0] WIDE_STACK_TOP = 32'hFFFF_FFFF;
  localparam logic [31:0] NARROW_STACK_TOP = 32'h0000_FFFF;

  // ----------------------------------------------------------------
  // Register map (APB, byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_STATUS = 8'h00;
  localparam logic [7:0] ADDR_CLEAR = 8'h04;
  localparam logic [7:0] ADDR_ENABLE = 8'h08;
  localparam logic [7:0] ADDR_LAST = 8'h0C;
  localparam logic [7:0] ADDR_COUNT = 8'h10;
  localparam logic [2:0] ENABLE_RESET = 3'h0;
  localparam int EVT_NOT_PRESENT = 0;
  localparam int EVT_PROTECTION = 1;
  localparam int EVT_DONE = 2;

  typedef enum logic [2:0] {
    USE_DATA = 3'h1,
    USE_CODE = 3'h2,
    USE_SYSTEM = 3'h4
  } use_type;

endpackage

// ==== design/desc_field_split.sv ====
`timescale 1ns/1ps
module desc_field_split
  import seg_desc_pkg::*;
(
  // Raw descriptor
  input wire logic [63:0] desc,
  // Fields
  output logic [31:0] base,
  output logic [31:0] limitBytes,
  output logic [7:0] accessByte,
  output logic [11:0] attrBits,
  output logic legacyForm
);
  logic [19:0] rawLimit;

  always_comb
  begin
    accessByte = desc[47:40];
    attrBits = {desc[55:52], desc[47:40]};
    legacyForm = (desc[63:48] == 16'h0000) && !desc[CLASS_BIT + 40];
    if (legacyForm)
    begin
      base = {8'h00, desc[39:16]};
      rawLimit = {4'h0, desc[15:0]};
    end
    else
    begin
      base = {desc[63:56], desc[39:16]};
      rawLimit = {desc[51:48], desc[15:0]};
    end
    // Granularity scaling ignores paging entirely
    if (desc[GRAN_BIT] && !legacyForm)
      limitBytes = {rawLimit, PAGE_FILL};
    else
      limitBytes = {12'h000, rawLimit};
  end
endmodule // desc_field_split

// ==== design/irq_status_bank.sv ====
`timescale 1ns/1ps
module irq_status_bank
  import seg_desc_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Events and software control
  input wire logic [2:0] events,
  input wire logic [2:0] clearBits,
  input wire logic enableWrite,
  input wire logic [2:0] enableData,
  // State
  output logic [2:0] status_q,
  output logic [2:0] enable_q,
  output logic irq_q
);
  logic [2:0] status_d;
  logic [2:0] enable_d;
  logic irq_d;

  always_comb
  begin
    // Set wins over a clear in the same cycle
    status_d = (status_q & ~clearBits) | events;
    enable_d = enableWrite ? enableData : enable_q;
    irq_d = |(status_d & enable_d);
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      status_q <= 3'h0;
      enable_q <= ENABLE_RESET;
      irq_q <= 1'b0;
    end
    else
    begin
      status_q <= status_d;
      enable_q <= enable_d;
      irq_q <= irq_d;
    end
  end
endmodule // irq_status_bank

// ==== design/segment_descriptor_decoder.sv ====
`timescale 1ns/1ps
module segment_descriptor_decoder
  import seg_desc_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Descriptor check request
  input wire logic reqValid,
  input wire logic [63:0] reqDesc,
  input wire logic [1:0] reqUse,
  input wire logic reqFromGlobal,
  input wire logic reqWrite,
  input wire logic reqRead,
  input wire logic reqStack,
  input wire logic [31:0] reqOffset,
  input wire logic [1:0] current_level,
  // Decoded result
  output logic resValid_q,
  output logic [63:0] resDesc_q,
  output logic [31:0] resBase_q,
  output logic [31:0] resLimit_q,
  output logic [11:0] resAttr_q,
  output logic [1:0] descriptor_level_q,
  output logic [1:0] newLevel_q,
  output logic isCode_q,
  output logic isData_q,
  output logic isLocalTable_q,
  output logic isTask_q,
  output logic taskBusy_q,
  output logic taskWide_q,
  output logic legacy_q,
  output logic wideOperand_q,
  output logic [31:0] stackTop_q,
  output logic fault_q,
  output logic [7:0] faultVec_q,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata_q,
  output logic pready_q,
  output logic pslverr_q,
  // Interrupt
  output logic irq_q
);

  // ----------------------------------------------------------------
  // Field split
  // ----------------------------------------------------------------
  logic [31:0] base;
  logic [31:0] limitBytes;
  logic [7:0] accessByte;
  logic [11:0] attrBits;
  logic legacyForm;

  desc_field_split desc_field_split_inst (
    .desc(reqDesc),
    .base(base),
    .limitBytes(limitBytes),
    .accessByte(accessByte),
    .attrBits(attrBits),
    .legacyForm(legacyForm)
  );

  // ----------------------------------------------------------------
  // Classification and checks
  // ----------------------------------------------------------------
  logic present;
  logic [1:0] level;
  logic classSet;
  logic codeSeg;
  logic dataSeg;
  logic [3:0] sysType;
  logic localTable;
  logic taskSeg;
  logic typeFault;
  logic accessFault;
  logic limitFault;
  logic levelFault;
  logic faultNow;
  logic [7:0] vecNow;
  logic [1:0] nextLevel;
  logic [31:0] stackTop;
  use_type useKind;

  always_comb
  begin
    unique case (reqUse)
      2'd1: useKind = USE_CODE;
      2'd2: useKind = USE_SYSTEM;
      default: useKind = USE_DATA;
    endcase
    present = accessByte[PRESENT_BIT];
    level = accessByte[LEVEL_HI:LEVEL_LO];
    classSet = accessByte[CLASS_BIT];
    codeSeg = classSet && accessByte[EXEC_BIT];
    dataSeg = classSet && !accessByte[EXEC_BIT];
    sysType = accessByte[3:0];
    localTable = !classSet && (sysType == TYPE_LOCAL_TABLE);
    taskSeg = !classSet && (sysType == TYPE_TASK_NARROW_FREE
      || sysType == TYPE_TASK_NARROW_BUSY || sysType == TYPE_TASK_WIDE_FREE
      || sysType == TYPE_TASK_WIDE_BUSY);
    typeFault = 1'b0;
    unique case (useKind)
      USE_CODE: typeFault = !codeSeg;
      USE_DATA: typeFault = !classSet || (codeSeg && !accessByte[RW_BIT]);
      USE_SYSTEM: typeFault = !(localTable || taskSeg);
    endcase
    accessFault = 1'b0;
    if (codeSeg)
    begin
      accessFault = reqWrite
        || (reqRead && !accessByte[RW_BIT]);
    end
    else if (dataSeg)
    begin
      accessFault = (reqWrite && !accessByte[RW_BIT])
        || (reqStack && !accessByte[RW_BIT]);
    end
    // Stack top must be settled before the expand-down bound reads it
    stackTop = reqDesc[SIZE_BIT] ? WIDE_STACK_TOP : NARROW_STACK_TOP;
    if (dataSeg && accessByte[CONF_BIT])
      limitFault = (reqOffset <= limitBytes) || (reqOffset > stackTop);
    else
      limitFault = reqOffset > limitBytes;
    if (!classSet)
      limitFault = 1'b0;
    // Privilege: conforming code keeps the caller's level
    nextLevel = current_level;
    levelFault = 1'b0;
    if (codeSeg && accessByte[CONF_BIT])
      levelFault = current_level < level;
    else if (classSet)
    begin
      levelFault = current_level > level;
      if (codeSeg)
        nextLevel = level;
    end
    if (localTable)
      levelFault = !reqFromGlobal;
    faultNow = 1'b1;
    vecNow = VEC_PROTECTION;
    if (!present)
      vecNow = VEC_NOT_PRESENT;
    else if (!(typeFault || accessFault || limitFault || levelFault))
      faultNow = 1'b0;
  end

  // ----------------------------------------------------------------
  // Result registers
  // ----------------------------------------------------------------
  logic resValid_d;
  logic [63:0] resDesc_d;
  logic [31:0] resBase_d;
  logic [31:0] resLimit_d;
  logic [11:0] resAttr_d;
  logic [1:0] dl_d;
  logic [1:0] newLevel_d;
  logic [7:0] flags_d;
  logic [31:0] stackTop_d;
  logic fault_d;
  logic [7:0] faultVec_d;
  logic [15:0] count_q;
  logic [15:0] count_d;

  always_comb
  begin
    resValid_d = reqValid;
    resDesc_d = resDesc_q;
    resBase_d = resBase_q;
    resLimit_d = resLimit_q;
    resAttr_d = resAttr_q;
    dl_d = descriptor_level_q;
    newLevel_d = newLevel_q;
    flags_d = {isCode_q, isData_q, isLocalTable_q, isTask_q, taskBusy_q, taskWide_q,
      legacy_q, wideOperand_q};
    stackTop_d = stackTop_q;
    fault_d = fault_q;
    faultVec_d = faultVec_q;
    count_d = count_q;
    if (reqValid)
    begin
      resDesc_d = reqDesc;
      resDesc_d[40 + ACCESSED_BIT] = 1'b1;
      // Not-present descriptors report zero in resBase_q and resLimit_q; resDesc_q still carries the raw base and limit
      resBase_d = present ? base : 32'h0000_0000;
      resLimit_d = present ? limitBytes : 32'h0000_0000;
      resAttr_d = attrBits;
      dl_d = level;
      newLevel_d = faultNow ? current_level : nextLevel;
      flags_d = {codeSeg, dataSeg, localTable, taskSeg, taskSeg && sysType[1],
        taskSeg && sysType[3], legacyForm, reqDesc[SIZE_BIT]};
      stackTop_d = stackTop;
      fault_d = faultNow;
      faultVec_d = faultNow ? vecNow : 8'h00;
      count_d = count_q + 16'h0001;
    end
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      resValid_q <= 1'b0;
      resDesc_q <= 64'h0;
      resBase_q <= 32'h0;
      resLimit_q <= 32'h0;
      resAttr_q <= 12'h0;
      descriptor_level_q <= 2'h0;
      newLevel_q <= 2'h0;
      {isCode_q, isData_q, isLocalTable_q, isTask_q, taskBusy_q, taskWide_q,
        legacy_q, wideOperand_q} <= 8'h00;
      stackTop_q <= 32'h0;
      fault_q <= 1'b0;
      faultVec_q <= 8'h00;
      count_q <= 16'h0;
    end
    else
    begin
      resValid_q <= resValid_d;
      resDesc_q <= resDesc_d;
      resBase_q <= resBase_d;
      resLimit_q <= resLimit_d;
      resAttr_q <= resAttr_d;
      descriptor_level_q <= dl_d;
      newLevel_q <= newLevel_d;
      {isCode_q, isData_q, isLocalTable_q, isTask_q, taskBusy_q, taskWide_q,
        legacy_q, wideOperand_q} <= flags_d;
      stackTop_q <= stackTop_d;
      fault_q <= fault_d;
      faultVec_q <= faultVec_d;
      count_q <= count_d;
    end
  end

  // ----------------------------------------------------------------
  // Events and APB slave
  // ----------------------------------------------------------------
  logic [2:0] events;
  logic [2:0] status;
  logic [2:0] enable;
  logic apbAccess;
  logic [31:0] prdata_d;
  logic pready_d;
  logic pslverr_d;
  logic mapped;

  always_comb
  begin
    events = 3'h0;
    events[EVT_NOT_PRESENT] = reqValid && !present;
    events[EVT_PROTECTION] = reqValid && faultNow && present;
    events[EVT_DONE] = reqValid;
    apbAccess = psel && penable && !pready_q;
    mapped = (paddr == ADDR_STATUS) || (paddr == ADDR_CLEAR) || (paddr == ADDR_ENABLE)
      || (paddr == ADDR_LAST) || (paddr == ADDR_COUNT);
    prdata_d = prdata_q;
    pready_d = apbAccess;
    pslverr_d = apbAccess && !mapped;
    if (apbAccess && !pwrite)
    begin
      unique case (paddr)
        ADDR_STATUS: prdata_d = {29'h0, status};
        ADDR_ENABLE: prdata_d = {29'h0, enable};
        ADDR_LAST: prdata_d = {faultVec_q, 8'h00, 4'h0, resAttr_q};
        ADDR_COUNT: prdata_d = {16'h0, count_q};
        default: prdata_d = 32'h0000_0000;
      endcase
    end
  end

  irq_status_bank irq_status_bank_inst (
    .clk(clk),
    .sys_rst(sys_rst),
    .events(events),
    .clearBits((apbAccess && pwrite && paddr == ADDR_CLEAR) ? pwdata[2:0] : 3'h0),
    .enableWrite(apbAccess && pwrite && paddr == ADDR_ENABLE),
    .enableData(pwdata[2:0]),
    .status_q(status),
    .enable_q(enable),
    .irq_q(irq_q)
  );

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      prdata_q <= 32'h0;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end
    else
    begin
      prdata_q <= prdata_d;
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  a_absent_faults: assert property (reqValid && !reqDesc[47] |=> fault_q && faultVec_q == 8'h0B
    && resBase_q == 32'h0) else $error("absent descriptor not faulted");
  a_level_copied: assert property (reqValid |=> descriptor_level_q == $past(reqDesc[46:45]))
    else $error("descriptor level wrong");
  a_class_split: assert property (reqValid && !reqDesc[44] |=> !isCode_q && !isData_q)
    else $error("system descriptor classed as code or data");
  a_accessed_set: assert property (reqValid |=> resDesc_q[40]) else $error("accessed bit clear");
  a_page_scale: assert property (reqValid && reqDesc[47] && reqDesc[55] && reqDesc[63:48] != 0
    |=> resLimit_q[11:0] == 12'hFFF) else $error("page limit not scaled");
  a_code_nowrite: assert property (reqValid && reqWrite && reqDesc[44] && reqDesc[43]
    |=> fault_q) else $error("code write allowed");
  a_conform_level: assert property (reqValid && !fault_d && reqDesc[44:42] == 3'b111
    |=> newLevel_q == $past(current_level)) else $error("conforming level changed");
  a_stack_top: assert property (reqValid && !reqDesc[54] |=> stackTop_q == 32'h0000_FFFF)
    else $error("narrow stack top wrong");
  a_legacy_base: assert property (reqValid && reqDesc[63:48] == 0 && !reqDesc[44] && reqDesc[47]
    |=> resBase_q[31:24] == 8'h00 && legacy_q) else $error("legacy base wrong");
  a_local_global: assert property (reqValid && reqDesc[44:40] == 5'h02 && !reqFromGlobal
    |=> fault_q) else $error("local table outside global table");
  a_apb_one: assert property (psel && penable |-> ##[0:1] pready_q)
    else $error("apb answer late");
  c_fault: cover property (reqValid ##1 fault_q);
  c_code_ok: cover property (reqValid && reqDesc[44:43] == 2'b11 ##1 !fault_q);
  c_task: cover property (reqValid ##1 isTask_q && taskBusy_q);
  c_irq: cover property (irq_q);
endmodule // segment_descriptor_decoder

// ==== dv/desc_table_model.sv ====
`timescale 1ns/1ps
module desc_table_model
(
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Fetch port
  input wire logic rdReq,
  input wire logic [3:0] rdIndex,
  input wire logic [3:0] latency,
  output logic rdAck,
  output logic [63:0] rdDesc
);
  // ----------------------------------------------------------------
  // Table memory, filled by software in the bench
  // ----------------------------------------------------------------
  logic [63:0] mem [16];
  logic [3:0] idx_q;
  logic [3:0] cnt_q;

  // Between answers the data inverts each cycle so a stale read never looks valid
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      rdAck <= 1'b0;
      rdDesc <= 64'h0000_0000_0000_0000;
      cnt_q <= 4'h0;
      idx_q <= 4'h0;
    end
    else
    begin
      rdAck <= 1'b0;
      rdDesc <= ~rdDesc;
      if (rdReq)
      begin
        idx_q <= rdIndex;
        cnt_q <= latency;
      end
      else if (cnt_q == 4'h1)
      begin
        rdAck <= 1'b1;
        rdDesc <= mem[idx_q];
        cnt_q <= 4'h0;
      end
      else if (cnt_q > 4'h1)
        cnt_q <= cnt_q - 4'h1;
    end
  end
endmodule // desc_table_model

// ==== dv/segment_descriptor_decoder_test.sv ====
`timescale 1ns/1ps
module segment_descriptor_decoder_test import seg_desc_pkg::*;;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic reqValid = 0, reqFromGlobal = 0, reqWrite = 0, reqRead = 0, reqStack = 0;
  logic [63:0] reqDesc = '0, resDesc_q;
  logic [1:0] reqUse = '0, current_level = '0, descriptor_level_q, newLevel_q;
  logic [31:0] reqOffset = '0, pwdata = '0, prdata_q, resBase_q, resLimit_q, stackTop_q, q;
  logic psel = 0, penable = 0, pwrite = 0, pready_q, pslverr_q, irq_q, lastErr;
  logic [7:0] paddr = '0, faultVec_q;
  logic [11:0] resAttr_q;
  logic resValid_q, isCode_q, isData_q, isLocalTable_q, isTask_q, taskBusy_q, taskWide_q;
  logic legacy_q, wideOperand_q, fault_q, rdReq = 0, rdAck;
  logic [3:0] rdIndex = '0, latency = 4'h1;
  logic [63:0] rdDesc;
  logic [3:0] tt [4] = '{4'h1, 4'h3, 4'h9, 4'hB};
  int fails = 0;
  int cmp_count = 0;

  always #2.5 clk = ~clk;

  segment_descriptor_decoder segment_descriptor_decoder_inst (.clk(clk), .sys_rst(sys_rst),
    .reqValid(reqValid), .reqDesc(reqDesc), .reqUse(reqUse), .reqFromGlobal(reqFromGlobal),
    .reqWrite(reqWrite), .reqRead(reqRead), .reqStack(reqStack), .reqOffset(reqOffset),
    .current_level(current_level), .resValid_q(resValid_q), .resDesc_q(resDesc_q),
    .resBase_q(resBase_q), .resLimit_q(resLimit_q), .resAttr_q(resAttr_q),
    .descriptor_level_q(descriptor_level_q), .newLevel_q(newLevel_q), .isCode_q(isCode_q),
    .isData_q(isData_q), .isLocalTable_q(isLocalTable_q), .isTask_q(isTask_q),
    .taskBusy_q(taskBusy_q), .taskWide_q(taskWide_q), .legacy_q(legacy_q),
    .wideOperand_q(wideOperand_q), .stackTop_q(stackTop_q), .fault_q(fault_q),
    .faultVec_q(faultVec_q), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata_q(prdata_q), .pready_q(pready_q), .pslverr_q(pslverr_q),
    .irq_q(irq_q));

  desc_table_model desc_table_model_inst (.clk(clk), .sys_rst(sys_rst), .rdReq(rdReq),
    .rdIndex(rdIndex), .latency(latency), .rdAck(rdAck), .rdDesc(rdDesc));

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic stop_test;
    if (fails == 0 && cmp_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk(input logic [79:0] seen, input logic [79:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      fails++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  function automatic logic [63:0] mk(logic [31:0] b, logic [19:0] l, logic [7:0] a, logic [3:0] f);
    return {b[31:24], f, l[19:16], a, b[23:0], l[15:0]};
  endfunction

  task automatic put(input logic [3:0] i, input logic [63:0] d);
    desc_table_model_inst.mem[i] = d;
  endtask

  // Fetch from the table, then present the descriptor for one cycle
  task automatic run(logic [3:0] i, logic [1:0] u, logic g, w, r, s, logic [31:0] o, logic [1:0] c);
    int n;
    @(posedge clk);
    rdReq <= 1'b1;
    rdIndex <= i;
    @(posedge clk);
    rdReq <= 1'b0;
    n = 0;
    do begin @(posedge clk); n++; end while (rdAck !== 1'b1 && n < 20);
    if (rdAck !== 1'b1) begin fails++; stop_test; end
    reqValid <= 1'b1;
    reqDesc <= rdDesc;
    {reqUse, reqFromGlobal, reqWrite, reqRead, reqStack} <= {u, g, w, r, s};
    reqOffset <= o;
    current_level <= c;
    @(posedge clk);
    reqValid <= 1'b0;
    n = 0;
    do begin @(posedge clk); n++; end while (resValid_q !== 1'b1 && n < 4);
    if (resValid_q !== 1'b1) begin fails++; stop_test; end
  endtask

  task automatic fc(logic [3:0] i, logic [1:0] u, logic g, w, r, s, logic [31:0] o, logic [1:0] c,
                    logic f);
    run(i, u, g, w, r, s, o, c);
    chk(fault_q, f);
    chk(faultVec_q, f ? VEC_PROTECTION : 8'h00);
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, wr, a, d};
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin @(posedge clk); n++; end while (pready_q !== 1'b1 && n < 8);
    if (pready_q !== 1'b1) begin fails++; stop_test; end
    q = prdata_q;
    lastErr = pslverr_q;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial
  begin
    put(0, mk(32'hAABB_CCDD, 20'h1_2345, 8'h52, 4'h4));
    put(1, mk(32'hAABB_CCDD, 20'h1_2345, 8'hD2, 4'h4));
    put(2, mk(32'h0001_0000, 20'h0_0012, 8'h92, 4'h8));
    put(3, mk(32'h0, 20'hF_FFFF, 8'h98, 4'h4));
    put(4, mk(32'h0, 20'hF_FFFF, 8'h9A, 4'h4));
    put(5, mk(32'h0, 20'hF_FFFF, 8'hBE, 4'h4));
    put(6, mk(32'h0, 20'h0_0FFF, 8'h96, 4'h0));
    put(7, mk(32'h0, 20'hF_FFFF, 8'h90, 4'h4));
    put(9, mk(32'hAB00_1000, 20'h0_0067, 8'h89, 4'h0));
    put(10, mk(32'h0020_0000, 20'h0_00FF, 8'hE2, 4'h0));
    put(11, mk(32'h0020_0000, 20'h0_00FF, 8'h80, 4'h0));
    repeat (10) @(posedge clk);
    sys_rst <= 1'b0;
    apb(1'b1, ADDR_CLEAR, 32'h0000_0007);
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk(q, 32'h0);
    run(0, 2'd0, 1, 0, 1, 0, 32'h0, 2'd2);
    chk({fault_q, faultVec_q, resBase_q, resLimit_q}, {1'b1, VEC_NOT_PRESENT, 64'h0});
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk({q, irq_q}, {32'h0000_0005, 1'b0});
    apb(1'b1, ADDR_ENABLE, 32'h0000_0001);
    apb(1'b0, ADDR_ENABLE, 32'h0);
    chk({q, irq_q}, {32'h0000_0001, 1'b1});
    apb(1'b1, ADDR_CLEAR, 32'h0000_0001);
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk({q, irq_q}, {32'h0000_0004, 1'b0});
    apb(1'b0, 8'h20, 32'h0);
    chk({q, lastErr}, {32'h0, 1'b1});
    latency <= 4'h5;
    run(1, 2'd0, 1, 1, 0, 0, 32'h100, 2'd2);
    chk({fault_q, resBase_q, resLimit_q}, {1'b0, 32'hAABB_CCDD, 32'h0001_2345});
    chk(resAttr_q[11:1], {4'h4, 7'h69});
    chk(resDesc_q, mk(32'hAABB_CCDD, 20'h1_2345, 8'hD3, 4'h4));
    chk({descriptor_level_q, newLevel_q}, 4'hA);
    chk({isData_q, isCode_q}, 2'b10);
    chk({wideOperand_q, stackTop_q}, {1'b1, WIDE_STACK_TOP});
    fc(1, 2'd0, 1, 0, 1, 0, 32'h100, 2'd3, 1);
    latency <= 4'h1;
    run(2, 2'd0, 1, 0, 1, 0, 32'h0, 2'd0);
    chk(resLimit_q, 32'h0001_2FFF);
    chk({wideOperand_q, stackTop_q}, {1'b0, NARROW_STACK_TOP});
    fc(3, 2'd1, 1, 0, 0, 0, 32'h10, 2'd0, 0);
    chk(isCode_q, 1);
    fc(3, 2'd0, 1, 0, 1, 0, 32'h10, 2'd0, 1);
    fc(4, 2'd3, 1, 0, 1, 0, 32'h10, 2'd0, 0);
    fc(4, 2'd0, 1, 1, 0, 0, 32'h10, 2'd0, 1);
    fc(5, 2'd1, 1, 0, 0, 0, 32'h10, 2'd3, 0);
    chk(newLevel_q, 2'd3);
    fc(5, 2'd1, 1, 0, 0, 0, 32'h10, 2'd0, 1);
    fc(6, 2'd0, 1, 1, 0, 0, 32'h0FFF, 2'd0, 1);
    fc(6, 2'd0, 1, 1, 0, 0, 32'h1000, 2'd0, 0);
    fc(1, 2'd0, 1, 0, 1, 0, 32'h1_2346, 2'd2, 1);
    fc(1, 2'd0, 1, 0, 1, 0, 32'h1_2345, 2'd2, 0);
    fc(7, 2'd0, 1, 1, 0, 0, 32'h10, 2'd0, 1);
    fc(7, 2'd0, 1, 0, 0, 1, 32'h10, 2'd0, 1);
    fc(1, 2'd0, 1, 1, 0, 1, 32'h10, 2'd2, 0);
    for (int i = 0; i < 4; i++)
    begin
      put(8, {16'h0000, 4'h8, tt[i], 24'h12_3456, 16'hABCD});
      fc(8, 2'd2, 1, 0, 1, 0, 32'h0, 2'd0, 0);
      chk({isTask_q, taskBusy_q, taskWide_q}, {1'b1, tt[i][1], tt[i][3]});
      chk({legacy_q, resBase_q, resLimit_q}, {1'b1, 32'h0012_3456, 32'h0000_ABCD});
    end
    fc(9, 2'd2, 1, 0, 1, 0, 32'h0, 2'd0, 0);
    chk({legacy_q, resBase_q}, {1'b0, 32'hAB00_1000});
    fc(10, 2'd2, 1, 0, 1, 0, 32'h0, 2'd3, 0);
    chk({isLocalTable_q, isData_q, isCode_q}, 3'b100);
    fc(10, 2'd2, 0, 0, 1, 0, 32'h0, 2'd0, 1);
    fc(11, 2'd2, 1, 0, 1, 0, 32'h0, 2'd0, 1);
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk(q[2:0], 3'h6);
    apb(1'b0, ADDR_COUNT, 32'h0);
    chk(q, 32'h0000_0019);
    apb(1'b0, ADDR_LAST, 32'h0);
    chk(q, 32'h0D00_0080);
    stop_test;
  end
endmodule // segment_descriptor_decoder_test
